// *** src/io_coherency_event_select.v ***
// Event selector and event counter pair for the io ring port monitor.
// Assumes all event inputs come from logic on clk; no synchronisers needed.
//
// Overview of operation
// - Write cache occupancy adds outstanding reads and writes.
// - Cache mask bits: any source, snoops, memory.
// - Clock tick event adds one every cycle.
// - Coherent ops count up to two, mask-selected types.
// - Fire-and-forget allocation, full, inserts, occupancy events.
// - All-buffer event: inbound, outbound, evictions, up to three.
// - Misc set A counts fastpath requests and rejects.
// - Misc set A secondary inserts need fastpath bits clear.
// - Misc set A transfer events need low bits clear.
// - Misc set B counts slow transfers and lost forwards.
// - Misc set B received events need low bits clear.
// - Peer requests one per cycle, occupancy up to 63.
// - Peer traffic types combine by OR.
// - Peer locality filter: remote, local or all.
// - Peer target match bits for remote or local.
// - Snoop replies up to two, response and type bits.
// - Inbound transactions OR types, AND source qualifier.
// - Inbound type bits; retried writes count again.
// - Source select bit limits to one filtered queue.
// - Data egress and ack egress events provided.
// - Two counters, each forty-eight bits wide.
// - Either counter counts any event of the port.
// - Increment width bounded per cycle.
`timescale 1ns/1ps
`include "io_coherency_event_select_consts.vh"

module io_coherency_event_select (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [15:0] ctl0,
    input wire [15:0] ctl1,
    input wire [8:0] wc_occ_any,
    input wire [8:0] wc_occ_snoop,
    input wire [8:0] wc_occ_mem,
    input wire [1:0] coh_op_valid,
    input wire [2:0] coh_op_type0,
    input wire [2:0] coh_op_type1,
    input wire faf_alloc,
    input wire faf_full,
    input wire faf_read_insert,
    input wire [4:0] faf_occ,
    input wire inbound_insert,
    input wire outbound_insert,
    input wire buffer_evict,
    input wire [7:0] misc_a_evt,
    input wire [6:0] misc_b_evt,
    input wire peer_req_insert,
    input wire [5:0] peer_occ,
    input wire peer_txn_valid,
    input wire [1:0] peer_txn_type,
    input wire peer_txn_remote,
    input wire peer_txn_tgt_match,
    input wire [1:0] snoop_valid,
    input wire [1:0] snoop_resp0,
    input wire [1:0] snoop_kind0,
    input wire [1:0] snoop_resp1,
    input wire [1:0] snoop_kind1,
    input wire txn_valid,
    input wire [1:0] txn_type,
    input wire [4:0] txn_source,
    input wire [4:0] source_queue_filter_field,
    input wire data_egress_insert,
    input wire data_egress_full,
    input wire [5:0] data_egress_occ,
    input wire ack_egress_alloc,
    input wire ncb_egress_full,
    output reg [8:0] inc0_reg,
    output reg [8:0] inc1_reg,
    output reg [47:0] count0_reg,
    output reg [47:0] count1_reg
);

    wire [8:0] inc0_next;
    wire [8:0] inc1_next;

    // Widen a single event bit to increment width.
    function [8:0] one;
        input b;
        begin
            one = {8'h00, b};
        end
    endfunction

    // Count set bits of a masked event vector and clip at two per cycle.
    function [8:0] sat_two;
        input [7:0] v;
        reg [3:0] pc;
        integer i;
        begin
            pc = 4'h0;
            for (i = 0; i < 8; i = i + 1) begin
                pc = pc + {3'b000, v[i]};
            end
            if ({5'h00, pc} > `MAX_TWO_PER_CYCLE) begin
                sat_two = `MAX_TWO_PER_CYCLE;
            end else begin
                sat_two = {5'h00, pc};
            end
        end
    endfunction

    // Coherent op type index to its unit mask bit.
    function coh_hit;
        input [7:0] um;
        input [2:0] kind;
        begin
            case (kind)
                3'h0: coh_hit = um[0]; // current_read_op
                3'h1: coh_hit = um[3]; // read for ownership
                3'h2: coh_hit = um[4]; // invalidate_to_modified_op
                3'h3: coh_hit = um[6]; // writeback_to_invalid_op
                3'h4: coh_hit = um[7]; // line_flush_op
                default: coh_hit = 1'b0;
            endcase
        end
    endfunction

    // A snoop reply counts only when both its response and its type are picked.
    function snoop_hit;
        input [7:0] um;
        input [1:0] resp;
        input [1:0] kind;
        begin
            snoop_hit = um[resp] & (kind != 2'h3) & um[`UM_SNOOP_KIND_LSB + kind];
        end
    endfunction

    // Inbound transaction type index to its unit mask bit.
    function txn_hit;
        input [7:0] um;
        input [1:0] kind;
        begin
            case (kind)
                2'h0: txn_hit = um[1];
                2'h1: txn_hit = um[3];
                2'h2: txn_hit = um[4];
                default: txn_hit = um[5];
            endcase
        end
    endfunction

    // Turn one control word into this cycle's increment. Both counters use
    // the same decode, so either may count any event.
    function [8:0] event_inc;
        input [15:0] ctl;
        reg [7:0] code;
        reg [7:0] um;
        reg [10:0] wsum;
        reg [7:0] m;
        reg rem_sel;
        reg loc_sel;
        reg loc_ok;
        reg tgt_ok;
        reg src_ok;
        begin
            code = ctl[`CTL_CODE_MSB:`CTL_CODE_LSB];
            um = ctl[`CTL_UMASK_MSB:`CTL_UMASK_LSB];
            wsum = 11'h000;
            m = 8'h00;
            rem_sel = um[`UM_PEER_REMOTE_ONLY];
            loc_sel = um[`UM_PEER_LOCAL_ONLY];
            loc_ok = 1'b0;
            tgt_ok = 1'b0;
            src_ok = 1'b0;
            case (code)
                `EV_CLOCK_TICKS: begin
                    event_inc = 9'h001;
                end
                `EV_WRITE_CACHE_OCCUPANCY: begin
                    // Sources are summed; the sum is clipped at the per-cycle peak.
                    wsum = {2'b00, um[0] ? wc_occ_any : 9'h000}
                        + {2'b00, um[1] ? wc_occ_snoop : 9'h000}
                        + {2'b00, um[2] ? wc_occ_mem : 9'h000};
                    if (wsum > {2'b00, `MAX_WRITE_CACHE_OCC}) begin
                        event_inc = `MAX_WRITE_CACHE_OCC;
                    end else begin
                        event_inc = wsum[8:0];
                    end
                end
                `EV_COHERENT_OPS: begin
                    event_inc = one(coh_op_valid[0] & coh_hit(um, coh_op_type0))
                        + one(coh_op_valid[1] & coh_hit(um, coh_op_type1));
                end
                `EV_FAF_ALLOCATION: event_inc = one(faf_alloc);
                `EV_FAF_FULL_CYCLES: event_inc = one(faf_full);
                `EV_FAF_READ_INSERTIONS: event_inc = one(faf_read_insert);
                `EV_FAF_FILL_LEVEL: event_inc = {4'h0, faf_occ};
                `EV_ALL_BUFFER_ACTIVITY: begin
                    event_inc = one(um[0] & inbound_insert)
                        + one(um[1] & outbound_insert)
                        + one(um[2] & buffer_evict);
                end
                `EV_MISC_EVENT_SET_A: begin
                    // Groups are exclusive: a lower group being picked disables higher ones.
                    if ((um & `UM_MISC_A_FAST) != 8'h00) begin
                        m = um & `UM_MISC_A_FAST;
                    end else if ((um & `UM_MISC_A_SECONDARY) != 8'h00) begin
                        m = um & `UM_MISC_A_SECONDARY;
                    end else begin
                        m = um & `UM_MISC_A_TRANSFER;
                    end
                    event_inc = sat_two(misc_a_evt & m);
                end
                `EV_MISC_EVENT_SET_B: begin
                    if ((um & 8'h0F) != 8'h00) begin
                        m = um & `UM_MISC_B_SLOW;
                    end else begin
                        m = um & `UM_MISC_B_RECEIVED;
                    end
                    event_inc = sat_two({1'b0, misc_b_evt} & m);
                end
                `EV_PEER_REQUEST_INSERTIONS: event_inc = one(peer_req_insert);
                `EV_PEER_QUEUE_FILL_LEVEL: event_inc = {3'h0, peer_occ};
                `EV_PEER_TRAFFIC_COUNT: begin
                    loc_ok = (rem_sel == loc_sel) | (rem_sel & peer_txn_remote)
                        | (loc_sel & ~peer_txn_remote);
                    if (um[`UM_PEER_REMOTE_TGT] | um[`UM_PEER_LOCAL_TGT]) begin
                        tgt_ok = peer_txn_tgt_match
                            & ((um[`UM_PEER_REMOTE_TGT] & peer_txn_remote)
                            | (um[`UM_PEER_LOCAL_TGT] & ~peer_txn_remote));
                    end else begin
                        tgt_ok = 1'b1;
                    end
                    event_inc = one(peer_txn_valid & um[peer_txn_type]
                        & loc_ok & tgt_ok);
                end
                `EV_SNOOP_REPLY_COUNT: begin
                    event_inc = one(snoop_valid[0] & snoop_hit(um, snoop_resp0, snoop_kind0))
                        + one(snoop_valid[1] & snoop_hit(um, snoop_resp1, snoop_kind1));
                end
                `EV_INBOUND_TRANSACTIONS: begin
                    // Each retry is presented as a new request, so it counts again.
                    src_ok = ~um[`UM_TXN_SOURCE_QUEUE]
                        | (txn_source == source_queue_filter_field);
                    event_inc = one(txn_valid & txn_hit(um, txn_type) & src_ok);
                end
                `EV_DATA_EGRESS_INSERTIONS: event_inc = one(data_egress_insert);
                `EV_DATA_EGRESS_FULL_CYCLES: event_inc = one(data_egress_full);
                `EV_DATA_EGRESS_FILL_LEVEL: event_inc = {3'h0, data_egress_occ};
                `EV_ACK_EGRESS_ALLOCATIONS: event_inc = one(ack_egress_alloc);
                `EV_NONCOHERENT_BYPASS_EGRESS_FULL: event_inc = one(ncb_egress_full);
                default: event_inc = 9'h000;
            endcase
        end
    endfunction

    // Same decode for both counters.
    assign inc0_next = event_inc(ctl0);
    assign inc1_next = event_inc(ctl1);

    // Increments are registered first so the adders see a clean flop output;
    // this costs one cycle of latency between event and count.
    always @(posedge clk) begin
        if (srst) begin
            inc0_reg <= 9'h000;
            inc1_reg <= 9'h000;
        end else if (ce) begin
            inc0_reg <= inc0_next;
            inc1_reg <= inc1_next;
        end
    end

    // The counter pair wraps silently at full scale.
    always @(posedge clk) begin
        if (srst) begin
            count0_reg <= 48'h000000000000;
            count1_reg <= 48'h000000000000;
        end else if (ce) begin
            count0_reg <= count0_reg + {39'h0, inc0_reg};
            count1_reg <= count1_reg + {39'h0, inc1_reg};
        end
    end

endmodule // io_coherency_event_select

// *** src/io_coherency_event_select_consts.vh ***
// Constants for the io ring port event selector: event codes, unit mask
// fields, per-cycle maxima and counter widths.
// Assumes inclusion by the selector module only; definitions only.
`ifndef IO_COHERENCY_EVENT_SELECT_CONSTS_VH
`define IO_COHERENCY_EVENT_SELECT_CONSTS_VH

// Control word layout.
`define CTL_CODE_LSB 0
`define CTL_CODE_MSB 7
`define CTL_UMASK_LSB 8
`define CTL_UMASK_MSB 15

// Widths.
`define CTR_WIDTH 48
`define INC_WIDTH 9

// Event codes.
`define EV_CLOCK_TICKS 8'h01
`define EV_DATA_EGRESS_INSERTIONS 8'h02
`define EV_DATA_EGRESS_FULL_CYCLES 8'h05
`define EV_NONCOHERENT_BYPASS_EGRESS_FULL 8'h06
`define EV_DATA_EGRESS_FILL_LEVEL 8'h08
`define EV_ACK_EGRESS_ALLOCATIONS 8'h0B
`define EV_WRITE_CACHE_OCCUPANCY 8'h0F
`define EV_COHERENT_OPS 8'h10
`define EV_INBOUND_TRANSACTIONS 8'h11
`define EV_SNOOP_REPLY_COUNT 8'h12
`define EV_PEER_TRAFFIC_COUNT 8'h13
`define EV_PEER_REQUEST_INSERTIONS 8'h14
`define EV_PEER_QUEUE_FILL_LEVEL 8'h15
`define EV_FAF_ALLOCATION 8'h16
`define EV_FAF_FULL_CYCLES 8'h17
`define EV_FAF_READ_INSERTIONS 8'h18
`define EV_FAF_FILL_LEVEL 8'h19
`define EV_MISC_EVENT_SET_A 8'h1E
`define EV_MISC_EVENT_SET_B 8'h1F
`define EV_ALL_BUFFER_ACTIVITY 8'h20

// Per-cycle maxima.
`define MAX_WRITE_CACHE_OCC 9'h1FF
`define MAX_TWO_PER_CYCLE 9'h002

// Unit mask bit positions and group masks.
`define UM_PEER_REMOTE_ONLY 4
`define UM_PEER_REMOTE_TGT 5
`define UM_PEER_LOCAL_ONLY 6
`define UM_PEER_LOCAL_TGT 7
`define UM_SNOOP_KIND_LSB 4
`define UM_TXN_SOURCE_QUEUE 6
`define UM_MISC_A_FAST 8'h03
`define UM_MISC_A_SECONDARY 8'h1C
`define UM_MISC_A_TRANSFER 8'hE0
`define UM_MISC_B_SLOW 8'h1F
`define UM_MISC_B_RECEIVED 8'h7F

`endif

// *** tb/io_coherency_event_select_monitor.sv ***
// Concurrent checks on the event selector outputs.
// Assumes it is bound to the selector top and sees only its ports.
`timescale 1ns/1ps
module io_coherency_event_select_monitor (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [15:0] ctl0,
    input wire [15:0] ctl1,
    input wire [4:0] faf_occ,
    input wire [5:0] peer_occ,
    input wire [8:0] inc0_reg,
    input wire [8:0] inc1_reg,
    input wire [47:0] count0_reg,
    input wire [47:0] count1_reg
);
    // One clock domain, so reset masks every check but the reset check itself.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_tick_adds_one: assert property (ce && ctl0 == 16'h0001 |=> inc0_reg == 9'h001)
        else $error("tick increment wrong");
    a_unknown_code_zero: assert property (
        ce && ctl1[7:0] == 8'h03 |=> inc1_reg == 9'h000)
        else $error("unassigned code counted");
    a_coh_ops_bound: assert property (ce && ctl0[7:0] == 8'h10 |=> inc0_reg <= 9'h002)
        else $error("coherent ops above two");
    a_faf_fill_pass: assert property (
        ce && ctl0[7:0] == 8'h19 |=> inc0_reg == {4'h0, $past(faf_occ)})
        else $error("queue fill level not added");
    a_peer_fill_pass: assert property (
        ce && ctl1[7:0] == 8'h15 |=> inc1_reg == {3'h0, $past(peer_occ)})
        else $error("peer fill level not added");
    a_count_accum: assert property (
        ce |=> count0_reg == $past(count0_reg) + $past(inc0_reg))
        else $error("counter did not add increment");
    a_freeze_hold: assert property (!ce |=> $stable(count1_reg) && $stable(inc1_reg))
        else $error("frozen cycle changed outputs");
    a_reset_clears: assert property (
        disable iff (1'b0) srst |=> count1_reg == 48'h0 && inc1_reg == 9'h000)
        else $error("reset left state");
    // Main scenarios reached.
    cover property (ctl0[7:0] == 8'h0F && inc0_reg > 9'h0FF);
    cover property (!ce ##1 ce);
    cover property (ctl1[7:0] == 8'h12 ##1 inc1_reg == 9'h002);
endmodule // io_coherency_event_select_monitor

// *** tb/ctl_word_source.sv ***
// Stand-in for the counter control registers that software programs.
// Assumes the caller loads words just after a falling clock edge.
`timescale 1ns/1ps
module ctl_word_source (
    output reg [15:0] ctl0,
    output reg [15:0] ctl1
);
    // Both words start on an unassigned code so nothing counts by surprise.
    initial begin
        ctl0 = 16'h0000;
        ctl1 = 16'h0000;
    end
    // Unit mask sits in the high byte, event code in the low byte.
    task load(input [15:0] w0, input [15:0] w1);
        begin
            ctl0 = w0;
            ctl1 = w1;
        end
    endtask
endmodule // ctl_word_source

// *** tb/io_coherency_event_select_bench.sv ***
// Self-checking bench for the io ring port event selector.
// Assumes a 40 MHz clock; all inputs change at the falling edge.
`timescale 1ns/1ps
module io_coherency_event_select_bench;
    reg clk, srst, ce;
    wire [15:0] ctl0, ctl1;
    reg [8:0] wc_occ_any, wc_occ_snoop, wc_occ_mem;
    reg [1:0] coh_op_valid, peer_txn_type, snoop_valid, snoop_resp0, snoop_kind0;
    reg [1:0] snoop_resp1, snoop_kind1, txn_type;
    reg [2:0] coh_op_type0, coh_op_type1;
    reg faf_alloc, faf_full, faf_read_insert, inbound_insert, outbound_insert, buffer_evict;
    reg peer_req_insert, peer_txn_valid, peer_txn_remote, peer_txn_tgt_match, txn_valid;
    reg data_egress_insert, data_egress_full, ack_egress_alloc, ncb_egress_full;
    reg [4:0] faf_occ, txn_source, source_queue_filter_field;
    reg [5:0] peer_occ, data_egress_occ;
    reg [7:0] misc_a_evt;
    reg [6:0] misc_b_evt;
    wire [8:0] inc0_reg, inc1_reg;
    wire [47:0] count0_reg, count1_reg;
    integer err_count, total_checks;

    io_coherency_event_select io_coherency_event_select_inst (
        .clk(clk), .srst(srst), .ce(ce), .ctl0(ctl0), .ctl1(ctl1),
        .wc_occ_any(wc_occ_any), .wc_occ_snoop(wc_occ_snoop), .wc_occ_mem(wc_occ_mem),
        .coh_op_valid(coh_op_valid), .coh_op_type0(coh_op_type0), .coh_op_type1(coh_op_type1),
        .faf_alloc(faf_alloc), .faf_full(faf_full), .faf_read_insert(faf_read_insert),
        .faf_occ(faf_occ), .inbound_insert(inbound_insert), .outbound_insert(outbound_insert),
        .buffer_evict(buffer_evict), .misc_a_evt(misc_a_evt), .misc_b_evt(misc_b_evt),
        .peer_req_insert(peer_req_insert), .peer_occ(peer_occ), .peer_txn_valid(peer_txn_valid),
        .peer_txn_type(peer_txn_type), .peer_txn_remote(peer_txn_remote),
        .peer_txn_tgt_match(peer_txn_tgt_match), .snoop_valid(snoop_valid),
        .snoop_resp0(snoop_resp0), .snoop_kind0(snoop_kind0), .snoop_resp1(snoop_resp1),
        .snoop_kind1(snoop_kind1), .txn_valid(txn_valid), .txn_type(txn_type),
        .txn_source(txn_source), .source_queue_filter_field(source_queue_filter_field),
        .data_egress_insert(data_egress_insert), .data_egress_full(data_egress_full),
        .data_egress_occ(data_egress_occ), .ack_egress_alloc(ack_egress_alloc),
        .ncb_egress_full(ncb_egress_full), .inc0_reg(inc0_reg), .inc1_reg(inc1_reg),
        .count0_reg(count0_reg), .count1_reg(count1_reg));
    ctl_word_source ctl_word_source_inst (.ctl0(ctl0), .ctl1(ctl1));

    // Free-running 25 ns clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare one value; four-state equality so an unknown never matches.
    task chk(input [8*6:1] name, input [47:0] exp, input [47:0] seen);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask

    // The increment is registered on the same edge that samples the words.
    task ev(input [15:0] w0, input [15:0] w1, input [8:0] e0, input [8:0] e1);
        begin
            ctl_word_source_inst.load(w0, w1);
            @(negedge clk);
            chk("inc0", {39'h0, e0}, inc0_reg);
            chk("inc1", {39'h0, e1}, inc1_reg);
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // Watchdog: a stalled run still reaches the verdict, counted as a mismatch.
    initial begin
        #(25.0 * 5000);
        err_count = err_count + 1;
        results;
    end

    // Event inputs are set as levels, then both counters read them back.
    initial begin
        err_count = 0;
        total_checks = 0;
        {wc_occ_any, wc_occ_snoop, wc_occ_mem, coh_op_valid, peer_txn_type, snoop_valid,
            snoop_resp0, snoop_kind0, snoop_resp1, snoop_kind1, txn_type, coh_op_type0,
            coh_op_type1, faf_alloc, faf_full, faf_read_insert, inbound_insert,
            outbound_insert, buffer_evict, peer_req_insert, peer_txn_valid, peer_txn_remote,
            peer_txn_tgt_match, txn_valid, data_egress_insert, data_egress_full,
            ack_egress_alloc, ncb_egress_full, faf_occ, txn_source, source_queue_filter_field,
            peer_occ, data_egress_occ, misc_a_evt, misc_b_evt} = '0;
        srst = 1'b1;
        ce = 1'b1;
        repeat (12) @(negedge clk);
        chk("cnt0", 48'h0, count0_reg);
        srst = 1'b0;
        ev(16'h0001, 16'h0003, 9'h001, 9'h000);
        {wc_occ_any, wc_occ_snoop, wc_occ_mem} = {9'h100, 9'h0FF, 9'h005};
        ev(16'h010F, 16'h070F, 9'h100, 9'h1FF);
        ev(16'h020F, 16'h040F, 9'h0FF, 9'h005);
        {coh_op_valid, coh_op_type0, coh_op_type1} = {2'h3, 3'h0, 3'h1};
        ev(16'h0110, 16'h0910, 9'h001, 9'h002);
        {coh_op_type0, coh_op_type1} = {3'h2, 3'h3};
        ev(16'h1010, 16'h4010, 9'h001, 9'h001);
        {coh_op_type0, coh_op_type1} = {3'h4, 3'h3};
        ev(16'h8010, 16'h1910, 9'h001, 9'h000);
        {faf_alloc, faf_full, faf_read_insert, faf_occ} = {3'b101, 5'h1F};
        ev(16'h0016, 16'h0017, 9'h001, 9'h000);
        ev(16'h0019, 16'h0018, 9'h01F, 9'h001);
        {inbound_insert, outbound_insert, buffer_evict} = 3'b111;
        ev(16'h0720, 16'h0220, 9'h003, 9'h001);
        misc_a_evt = 8'hFF;
        ev(16'h031E, 16'h041E, 9'h002, 9'h001);
        ev(16'h1C1E, 16'hE01E, 9'h002, 9'h002);
        misc_a_evt = 8'h1C;
        ev(16'h1F1E, 16'h401E, 9'h000, 9'h000);
        misc_b_evt = 7'h7F;
        ev(16'h011F, 16'h601F, 9'h001, 9'h002);
        {peer_req_insert, peer_occ} = {1'b1, 6'h3F};
        ev(16'h0014, 16'h0015, 9'h001, 9'h03F);
        {peer_txn_valid, peer_txn_type, peer_txn_remote, peer_txn_tgt_match} = 5'b10110;
        ev(16'h0313, 16'h0113, 9'h001, 9'h000);
        ev(16'h1213, 16'h4213, 9'h001, 9'h000);
        ev(16'h5213, 16'h2213, 9'h001, 9'h000);
        peer_txn_tgt_match = 1'b1;
        ev(16'h2213, 16'h8213, 9'h001, 9'h000);
        {snoop_valid, snoop_resp0, snoop_kind0, snoop_resp1, snoop_kind1} = 10'b1100011110;
        ev(16'h7112, 16'h7F12, 9'h001, 9'h002);
        ev(16'h7E12, 16'h0112, 9'h001, 9'h000);
        {txn_valid, txn_type, txn_source, source_queue_filter_field} = {3'b100, 10'h0A5};
        ev(16'h0211, 16'h4211, 9'h001, 9'h001);
        source_queue_filter_field = 5'h06;
        ev(16'h4211, 16'h8011, 9'h000, 9'h000);
        txn_type = 2'h3;
        ev(16'h2011, 16'h1811, 9'h001, 9'h000);
        {data_egress_insert, data_egress_full, data_egress_occ} = {2'b11, 6'h28};
        {ack_egress_alloc, ncb_egress_full} = 2'b10;
        ev(16'h0002, 16'h0005, 9'h001, 9'h001);
        ev(16'h000B, 16'h0006, 9'h001, 9'h000);
        // Mid-run reset, then ten edges of ticks and of a 40-entry fill level.
        ctl_word_source_inst.load(16'h0001, 16'h0008);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        chk("cnt1", 48'h0, count1_reg);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        chk("cnt0", 48'h9, count0_reg);
        chk("cnt1", 48'h168, count1_reg);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        chk("cnt1", 48'h168, count1_reg);
        ce = 1'b1;
        @(negedge clk);
        chk("cnt0", 48'hA, count0_reg);
        results;
    end
endmodule // io_coherency_event_select_bench

bind io_coherency_event_select io_coherency_event_select_monitor
    io_coherency_event_select_monitor_inst (.clk(clk), .srst(srst), .ce(ce), .ctl0(ctl0),
    .ctl1(ctl1), .faf_occ(faf_occ), .peer_occ(peer_occ), .inc0_reg(inc0_reg),
    .inc1_reg(inc1_reg), .count0_reg(count0_reg), .count1_reg(count1_reg));
